// *** hw/rtcsaw_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Two independent sub-second alarms A and B behave identically.
// - Each alarm compares its sub-second value with the running sub-second count.
// - Sub-second counter counts down to zero, then reloads the prescaler setting.
// - Compare width zero: alarm condition met on every seconds increment.
// - Compare width n compares only the n low sub-second bits.
// - The counter's overflow bit never enters the comparison.
// - Wakeup timer counts down, flags and interrupts at zero, then reloads.
// - Wakeup, alarm A or alarm B drive one shared pad, polarity selectable.
// - Keys 0xCA then 0x53 unlock writes, 0xFF relocks; locked writes ignored.
// - Write-allowed flag rises two cycles after wakeup enable is cleared.
// - Re-enabling restarts the wakeup count from the programmed reload.
// - Select codes 000 to 011 divide the kernel clock by 16, 8, 4, 2.
// - Codes 10x count one-second ticks with the 16-bit reload.
// - Codes 11x add 2^16 to the reload, counting from up to 0x1FFFF.
// - Wakeup period is effective reload plus one times the tick period.
// - Alarm settings accept writes only while disabled or in init mode.
module rtcsaw_top
    import rtcsaw_pkg::*;
(
    input  wire logic                core_clk,
    input  wire logic                rstn,
    input  wire logic                async_prescaler_tick,
    input  wire logic [SS_W-1:0]     prescaler_setting,
    input  wire logic                init_mode,
    input  wire logic                key_wr,
    input  wire logic [7:0]          key_data,
    input  wire logic                ctrl_wr,
    input  wire logic                wakeup_timer_enable_in,
    input  wire logic [1:0]          alarm_enable_in,
    input  wire logic [2:0]          wakeup_clock_select_in,
    input  wire logic [1:0]          out_select_in,
    input  wire logic                out_polarity_in,
    input  wire logic [2:0]          irq_enable_in,
    input  wire logic                reload_wr,
    input  wire logic [RELOAD_W-1:0] wakeup_reload_value_in,
    input  wire logic [1:0]          alarm_wr,
    input  wire logic [SS_W-1:0]     alarm_subsecond_value_in,
    input  wire logic [CMPW_W-1:0]   compare_width_in,
    input  wire logic [1:0]          alarm_time_match,
    input  wire logic [2:0]          flag_clear,
    output logic [SS_REG_W-1:0]      subsecond_counter_reg,
    output logic                     one_hz_prescaled_clock,
    output logic                     write_unlocked,
    output logic                     wakeup_timer_enable,
    output logic                     wakeup_write_allowed_flag,
    output logic [1:0]               alarm_write_allowed,
    output logic [RELOAD_W-1:0]      wakeup_reload_value,
    output logic [2:0]               wakeup_clock_select,
    output logic [WCNT_W-1:0]        wakeup_count,
    output logic [1:0]               alarm_flags,
    output logic                     wakeup_flag,
    output logic [2:0]               irq,
    output logic                     alarm_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rstn);

    // ****************************************************************
    // Write protection
    // ****************************************************************
    rtcsaw_wp_e wp_r, wp_nxt;

    always_comb begin
        wp_nxt = wp_r;
        if (key_wr) begin
            unique case (wp_r)
                WP_LOCKED: wp_nxt = (key_data == KEY_FIRST) ? WP_KEY1 : WP_LOCKED;
                WP_KEY1:   wp_nxt = (key_data == KEY_SECOND) ? WP_OPEN : WP_LOCKED;
                WP_OPEN:   wp_nxt = (key_data == KEY_RELOCK) ? WP_LOCKED : WP_OPEN;
                default:   wp_nxt = WP_LOCKED;
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wp_r <= WP_LOCKED;
        end else begin
            wp_r <= wp_nxt;
        end
    end

    assign write_unlocked = (wp_r == WP_OPEN);

    // ****************************************************************
    // Control and configuration
    // ****************************************************************
    logic                wen_r, wen_nxt;
    logic [1:0]          aen_r, aen_nxt;
    logic [2:0]          en_d1_r, en_d1_nxt;
    logic [2:0]          en_d2_r, en_d2_nxt;
    logic [2:0]          cksel_r, cksel_nxt;
    logic [1:0]          osel_r, osel_nxt;
    logic                opol_r, opol_nxt;
    logic [2:0]          ie_r, ie_nxt;
    logic [RELOAD_W-1:0] reload_r, reload_nxt;
    logic [SS_W-1:0]     ass_r [2], ass_nxt [2];
    logic [CMPW_W-1:0]   acw_r [2], acw_nxt [2];

    // Enables pass a two-stage pipe, mirroring the calendar-side handshake delay
    assign wakeup_write_allowed_flag = !wen_r && !en_d2_r[2];
    assign alarm_write_allowed       = ~aen_r & ~en_d2_r[1:0];

    always_comb begin
        wen_nxt    = wen_r;
        aen_nxt    = aen_r;
        cksel_nxt  = cksel_r;
        osel_nxt   = osel_r;
        opol_nxt   = opol_r;
        ie_nxt     = ie_r;
        reload_nxt = reload_r;
        ass_nxt    = ass_r;
        acw_nxt    = acw_r;
        en_d1_nxt  = {wen_r, aen_r};
        en_d2_nxt  = en_d1_r;
        if (write_unlocked && ctrl_wr) begin
            wen_nxt  = wakeup_timer_enable_in;
            aen_nxt  = alarm_enable_in;
            osel_nxt = out_select_in;
            opol_nxt = out_polarity_in;
            ie_nxt   = irq_enable_in;
            // Select only moves while the timer is idle or in init mode; a live change would skew a period
            if (wakeup_write_allowed_flag || init_mode) begin
                cksel_nxt = wakeup_clock_select_in;
            end
        end
        if (write_unlocked && reload_wr && (wakeup_write_allowed_flag || init_mode)) begin
            reload_nxt = wakeup_reload_value_in;
        end
        for (int i = 0; i < 2; i++) begin
            if (write_unlocked && alarm_wr[i] && (alarm_write_allowed[i] || init_mode)) begin
                ass_nxt[i] = alarm_subsecond_value_in;
                acw_nxt[i] = compare_width_in;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            wen_r    <= 1'b0;
            aen_r    <= 2'b00;
            en_d1_r  <= 3'b000;
            en_d2_r  <= 3'b000;
            cksel_r  <= CKSEL_RST;
            osel_r   <= OSEL_OFF;
            opol_r   <= 1'b0;
            ie_r     <= 3'b000;
            reload_r <= RELOAD_RST;
            ass_r    <= '{ALARM_SS_RST, ALARM_SS_RST};
            acw_r    <= '{CMPW_RST, CMPW_RST};
        end else begin
            wen_r    <= wen_nxt;
            aen_r    <= aen_nxt;
            en_d1_r  <= en_d1_nxt;
            en_d2_r  <= en_d2_nxt;
            cksel_r  <= cksel_nxt;
            osel_r   <= osel_nxt;
            opol_r   <= opol_nxt;
            ie_r     <= ie_nxt;
            reload_r <= reload_nxt;
            ass_r    <= ass_nxt;
            acw_r    <= acw_nxt;
        end
    end

    assign wakeup_timer_enable = wen_r;
    assign wakeup_reload_value = reload_r;
    assign wakeup_clock_select = cksel_r;

    // ****************************************************************
    // Sub-second counter
    // ****************************************************************
    logic [SS_W-1:0] ss_r, ss_nxt;
    logic            step_r, sec_r;

    always_comb begin
        ss_nxt = ss_r;
        if (async_prescaler_tick) begin
            ss_nxt = (ss_r == '0) ? prescaler_setting : ss_r - 15'h0001;
        end
    end

    // Step and second pulses line up with the cycle in which the new count is visible
    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            ss_r   <= SS_CNT_RST;
            step_r <= 1'b0;
            sec_r  <= 1'b0;
        end else begin
            ss_r   <= ss_nxt;
            step_r <= async_prescaler_tick;
            sec_r  <= async_prescaler_tick && ss_r == '0;
        end
    end

    // Bit 15 is the overflow position; this block never sets it
    assign subsecond_counter_reg  = {1'b0, ss_r};
    assign one_hz_prescaled_clock = sec_r;

    // ****************************************************************
    // Alarms and wakeup timer
    // ****************************************************************
    logic [1:0] alarm_event;
    rtcsaw_wk_if wk ();

    genvar ga;
    for (ga = 0; ga < 2; ga++) begin : g_alarm
        rtcsaw_ss_alarm u_alarm (
            .core_clk              (core_clk),
            .rstn                  (rstn),
            .alarm_enable          (aen_r[ga]),
            .alarm_subsecond_value (ass_r[ga]),
            .compare_width         (acw_r[ga]),
            .subsec_cnt            (ss_r),
            .subsec_step           (step_r),
            .second_tick           (sec_r),
            .other_fields_match    (alarm_time_match[ga]),
            .alarm_event           (alarm_event[ga])
        );
    end

    // Timer starts on the delayed enable but stops as soon as wen_r clears, two cycles before the flag rises
    assign wk.enable      = en_d2_r[2] && wen_r;
    assign wk.reload      = reload_r;
    assign wk.clksel      = cksel_r;
    assign wk.one_hz_tick = sec_r;

    rtcsaw_wakeup u_wakeup (
        .core_clk (core_clk),
        .rstn     (rstn),
        .wk       (wk)
    );
    assign wakeup_count = wk.count;

    // ****************************************************************
    // Flags, interrupts and shared pad
    // ****************************************************************
    logic [2:0] flag_r, flag_nxt;
    logic [2:0] evt;
    logic       pad_r, pad_nxt;

    assign evt = {wk.event_pulse, alarm_event};

    always_comb begin
        // A new event wins over a clear in the same cycle
        flag_nxt = evt | (flag_r & ~flag_clear);
        unique case (rtcsaw_osel_e'(osel_r))
            OSEL_ALARM_A: pad_nxt = flag_r[0] ^ opol_r;
            OSEL_ALARM_B: pad_nxt = flag_r[1] ^ opol_r;
            OSEL_WAKEUP:  pad_nxt = flag_r[2] ^ opol_r;
            OSEL_OFF:     pad_nxt = opol_r;
        endcase
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            flag_r <= 3'b000;
            pad_r  <= 1'b0;
        end else begin
            flag_r <= flag_nxt;
            pad_r  <= pad_nxt;
        end
    end

    assign alarm_flags = flag_r[1:0];
    assign wakeup_flag = flag_r[2];
    assign irq         = flag_r & ie_r;
    assign alarm_out   = pad_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_locked_ignore: assert property (!write_unlocked && ctrl_wr |=> $stable(wen_r))
        else $error("control write took effect while locked");
    a_key_sequence: assert property (
        wp_r == WP_LOCKED && key_wr && key_data == KEY_FIRST
        ##1 key_wr && key_data == KEY_SECOND |=> write_unlocked)
        else $error("unlock key pair did not open the registers");
    a_relock_key: assert property (write_unlocked && key_wr && key_data == KEY_RELOCK |=> !write_unlocked)
        else $error("relock key did not lock the registers");
    a_wf_two_cycles: assert property ($fell(wen_r) && en_d2_r[2] |-> !wakeup_write_allowed_flag
        ##1 !wakeup_write_allowed_flag ##1 wakeup_write_allowed_flag)
        else $error("write-allowed flag not raised two cycles after disable");
    a_reload_guard: assert property (!wakeup_write_allowed_flag && !init_mode |=> $stable(reload_r))
        else $error("reload value changed while the timer was running");
    a_ss_reload: assert property (async_prescaler_tick && ss_r == '0 |=> ss_r == $past(prescaler_setting))
        else $error("sub-second counter did not reload at zero");
    a_ss_down: assert property (async_prescaler_tick && ss_r != '0 |=> ss_r == $past(ss_r) - 15'h0001)
        else $error("sub-second counter did not count down");
    a_alarm_cfg_guard: assert property (aen_r[0] && en_d2_r[0] && !init_mode |=> $stable(ass_r[0]))
        else $error("alarm A setting changed while enabled");
    a_flag_set_wins: assert property (evt[0] && flag_clear[0] |=> alarm_flags[0] && irq[0] == ie_r[0])
        else $error("alarm event lost against a flag clear");
    a_pad_wakeup: assert property (osel_r == OSEL_WAKEUP |=> alarm_out == ($past(flag_r[2]) ^ $past(opol_r)))
        else $error("shared pad does not follow the wakeup flag");

    c_unlock: cover property (wp_r == WP_KEY1 ##1 write_unlocked);
    c_wakeup_fire: cover property (wk.event_pulse ##1 wakeup_flag);
    c_both_alarms: cover property (alarm_flags == 2'b11);
endmodule // rtcsaw_top
`default_nettype wire

// *** hw/rtcsaw_pkg.sv ***
// ****************************************************************
// Constants of the sub-second alarm and wakeup timer block
// ****************************************************************
package rtcsaw_pkg;

    localparam int          CLK_PERIOD_NS   = 50;
    localparam int          SS_W            = 15;
    localparam int          SS_REG_W        = 16;
    localparam int          CMPW_W          = 4;
    localparam int          RELOAD_W        = 16;
    localparam int          WCNT_W          = 17;
    localparam int          DIV_W           = 4;
    localparam int          WF_SYNC_CYCLES  = 2;

    localparam logic [7:0]  KEY_FIRST       = 8'hCA;
    localparam logic [7:0]  KEY_SECOND      = 8'h53;
    localparam logic [7:0]  KEY_RELOCK      = 8'hFF;

    localparam logic [14:0] SS_CNT_RST      = 15'h0000;
    localparam logic [14:0] ALARM_SS_RST    = 15'h0000;
    localparam logic [3:0]  CMPW_RST        = 4'h0;
    localparam logic [15:0] RELOAD_RST      = 16'hFFFF;
    localparam logic [2:0]  CKSEL_RST       = 3'h0;
    localparam logic [16:0] WCNT_RST        = 17'h00000;
    localparam logic [3:0]  DIV_RST         = 4'h0;

    // Clock select codes; 1xx uses the one-second tick, 11x adds bit 16
    localparam logic [2:0]  CKSEL_DIV16     = 3'h0;
    localparam logic [2:0]  CKSEL_DIV8      = 3'h1;
    localparam logic [2:0]  CKSEL_DIV4      = 3'h2;
    localparam logic [2:0]  CKSEL_DIV2      = 3'h3;
    localparam logic [1:0]  CKSEL_EXT_TOP   = 2'h3;

    typedef enum logic [1:0] {
        WP_LOCKED = 2'b00,
        WP_KEY1   = 2'b01,
        WP_OPEN   = 2'b11
    } rtcsaw_wp_e;

    typedef enum logic [1:0] {
        OSEL_OFF     = 2'h0,
        OSEL_ALARM_A = 2'h1,
        OSEL_ALARM_B = 2'h2,
        OSEL_WAKEUP  = 2'h3
    } rtcsaw_osel_e;

endpackage

// *** hw/rtcsaw_wk_if.sv ***
`timescale 1ns/1ps
`default_nettype none
// ****************************************************************
// Link between the register side and the wakeup timer
// ****************************************************************
interface rtcsaw_wk_if;
    logic        enable;
    logic [15:0] reload;
    logic [2:0]  clksel;
    logic        one_hz_tick;
    logic        event_pulse;
    logic [16:0] count;

    modport ctl (output enable, output reload, output clksel, output one_hz_tick,
                 input event_pulse, input count);
    modport tmr (input enable, input reload, input clksel, input one_hz_tick,
                 output event_pulse, output count);
endinterface
`default_nettype wire

// *** hw/rtcsaw_ss_alarm.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtcsaw_ss_alarm
    import rtcsaw_pkg::*;
(
    input  wire logic              core_clk,
    input  wire logic              rstn,
    input  wire logic              alarm_enable,
    input  wire logic [SS_W-1:0]   alarm_subsecond_value,
    input  wire logic [CMPW_W-1:0] compare_width,
    input  wire logic [SS_W-1:0]   subsec_cnt,
    input  wire logic              subsec_step,
    input  wire logic              second_tick,
    input  wire logic              other_fields_match,
    output logic                   alarm_event
);
    logic [SS_W-1:0] cmp_mask;
    logic            ss_match;

    // Bit i takes part only when it is below the compare width
    genvar gi;
    for (gi = 0; gi < SS_W; gi++) begin : g_mask
        assign cmp_mask[gi] = (CMPW_W'(gi) < compare_width);
    end

    // Only the 15 counting bits enter; the overflow bit never reaches here
    assign ss_match = ((alarm_subsecond_value ^ subsec_cnt) & cmp_mask) == '0;

    always_comb begin
        if (compare_width == '0) begin
            alarm_event = alarm_enable & other_fields_match & second_tick;
        end else begin
            alarm_event = alarm_enable & other_fields_match & subsec_step & ss_match;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_width_zero_sec: assert property (@(posedge core_clk) disable iff (!rstn)
        (compare_width == '0 && alarm_enable && other_fields_match && second_tick) |-> alarm_event)
        else $error("alarm missed the seconds increment with compare width zero");
    a_masked_bits: assert property (@(posedge core_clk) disable iff (!rstn)
        alarm_event && compare_width != '0 |->
        ((alarm_subsecond_value ^ subsec_cnt) & cmp_mask) == '0 && subsec_step)
        else $error("alarm fired although masked sub-second bits differ");
    c_masked_hit: cover property (@(posedge core_clk) disable iff (!rstn)
        alarm_event && compare_width == 4'hF);
endmodule // rtcsaw_ss_alarm
`default_nettype wire

// *** hw/rtcsaw_wakeup.sv ***
`timescale 1ns/1ps
`default_nettype none
module rtcsaw_wakeup
    import rtcsaw_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rstn,
    rtcsaw_wk_if.tmr  wk
);
    logic [DIV_W-1:0]  div_r, div_nxt;
    logic [WCNT_W-1:0] cnt_r, cnt_nxt;
    logic              run_r, run_nxt;
    logic              ev_r, ev_nxt;
    logic              tick;
    logic [WCNT_W-1:0] reload_eff;

    // Codes 11x extend the count with 2^16 added to the reload
    assign reload_eff = {(wk.clksel[2:1] == CKSEL_EXT_TOP), wk.reload};

    always_comb begin
        if (wk.clksel[2]) begin
            tick = wk.one_hz_tick;
        end else begin
            unique case (wk.clksel)
                CKSEL_DIV16: tick = (div_r == 4'hF);
                CKSEL_DIV8:  tick = (div_r[2:0] == 3'h7);
                CKSEL_DIV4:  tick = (div_r[1:0] == 2'h3);
                default:     tick = div_r[0];
            endcase
        end
    end

    always_comb begin
        div_nxt = div_r + 4'h1;
        run_nxt = wk.enable;
        cnt_nxt = cnt_r;
        ev_nxt  = 1'b0;
        if (wk.enable && !run_r) begin
            cnt_nxt = reload_eff;
        end else if (run_r && wk.enable && tick) begin
            if (cnt_r == '0) begin
                cnt_nxt = reload_eff;
                ev_nxt  = 1'b1;
            end else begin
                cnt_nxt = cnt_r - 17'h00001;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rstn) begin
        if (!rstn) begin
            div_r <= DIV_RST;
            cnt_r <= WCNT_RST;
            run_r <= 1'b0;
            ev_r  <= 1'b0;
        end else begin
            div_r <= div_nxt;
            cnt_r <= cnt_nxt;
            run_r <= run_nxt;
            ev_r  <= ev_nxt;
        end
    end

    assign wk.event_pulse = ev_r;
    assign wk.count       = cnt_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    a_wk_restart: assert property (@(posedge core_clk) disable iff (!rstn)
        wk.enable && !run_r |=> cnt_r == $past(reload_eff))
        else $error("wakeup counter did not restart from the reload value");
    a_wk_zero_reload: assert property (@(posedge core_clk) disable iff (!rstn)
        run_r && wk.enable && tick && cnt_r == '0 |=> ev_r && cnt_r == $past(reload_eff))
        else $error("wakeup counter reached zero without event and reload");
    a_wk_div16: assert property (@(posedge core_clk) disable iff (!rstn)
        wk.clksel == CKSEL_DIV16 && tick |=> !tick [*8] ##8 tick)
        else $error("divide-by-16 tick spacing is wrong");
    c_wk_event_ext: cover property (@(posedge core_clk) disable iff (!rstn)
        ev_r && wk.clksel[2]);
endmodule // rtcsaw_wakeup
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
    import rtcsaw_pkg::*;
    logic        core_clk, rstn, tick, key_wr, ctrl_wr, wen, pol, reload_wr;
    logic [7:0]  key_data;
    logic [1:0]  aen, osel, awr, awa, afl;
    logic [2:0]  sel, fclr, selo, irq;
    logic [15:0] rl, ssr, rlo;
    logic [14:0] av, ssm;
    logic [3:0]  cw;
    logic [16:0] wcnt;
    logic        hz, unl, wte, wwf, wfl, aout;
    int          miscompares, cmp_count;

    rtcsaw_top i_dut (.core_clk(core_clk), .rstn(rstn), .async_prescaler_tick(tick), .prescaler_setting(15'h0007),
        .init_mode(1'b0), .key_wr(key_wr), .key_data(key_data), .ctrl_wr(ctrl_wr), .wakeup_timer_enable_in(wen),
        .alarm_enable_in(aen), .wakeup_clock_select_in(sel), .out_select_in(osel), .out_polarity_in(pol),
        .irq_enable_in(3'h7), .reload_wr(reload_wr), .wakeup_reload_value_in(rl), .alarm_wr(awr),
        .alarm_subsecond_value_in(av), .compare_width_in(cw), .alarm_time_match(2'h3), .flag_clear(fclr),
        .subsecond_counter_reg(ssr), .one_hz_prescaled_clock(hz), .write_unlocked(unl), .wakeup_timer_enable(wte),
        .wakeup_write_allowed_flag(wwf), .alarm_write_allowed(awa), .wakeup_reload_value(rlo),
        .wakeup_clock_select(selo), .wakeup_count(wcnt), .alarm_flags(afl), .wakeup_flag(wfl), .irq(irq),
        .alarm_out(aout));

    // ****************************************************************
    // Drivers and checks
    // ****************************************************************
    task automatic clk_n(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic summarize();
        if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [16:0] exp, input logic [16:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic key(input logic [7:0] d);
        key_data = d;
        key_wr = 1'b1;
        clk_n(1);
        key_wr = 1'b0;
        clk_n(1);
    endtask
    task automatic ctrl(input logic w, input logic [1:0] a, input logic [2:0] s, input logic [1:0] o, input logic p);
        {wen, aen, sel, osel, pol} = {w, a, s, o, p};
        ctrl_wr = 1'b1;
        clk_n(1);
        ctrl_wr = 1'b0;
    endtask
    // Clears the wakeup flag in the same cycle, so stale events never count
    task automatic wr_rl(input logic [15:0] r);
        {rl, reload_wr, fclr} = {r, 1'b1, 3'h4};
        clk_n(1);
        {reload_wr, fclr} = 4'h0;
    endtask
    task automatic wait_wf(output int n);
        n = 1;
        while (wfl !== 1'b1 && n < 400) begin
            clk_n(1);
            n++;
        end
        if (n >= 400) begin
            miscompares++;
            summarize();
        end
    endtask

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_lock();
        ctrl(1'b1, 2'h0, 3'h0, 2'h0, 1'b0);
        clk_n(2);
        chk("locked_enable", 17'h0, {16'h0, wte});
        chk("reset_reload", 17'h0FFFF, {1'b0, rlo});
        key(KEY_FIRST);
        key(8'h12);
        clk_n(1);
        chk("bad_key_unlock", 17'h0, {16'h0, unl});
        key(KEY_FIRST);
        key(KEY_SECOND);
        clk_n(1);
        chk("unlock", 17'h1, {16'h0, unl});
    endtask
    task automatic t_wflag();
        ctrl(1'b1, 2'h0, 3'h0, 2'h0, 1'b0);
        chk("flag_with_enable", 17'h0, {16'h0, wwf});
        wr_rl(16'h0005);
        clk_n(1);
        chk("reload_refused", 17'h0FFFF, {1'b0, rlo});
        ctrl(1'b0, 2'h0, 3'h0, 2'h0, 1'b0);
        chk("flag_c1", 17'h0, {16'h0, wwf});
        clk_n(1);
        chk("flag_c2", 17'h0, {16'h0, wwf});
        clk_n(1);
        chk("flag_c3", 17'h1, {16'h0, wwf});
    endtask
    task automatic t_period(input logic [2:0] s, input logic [15:0] r, input logic p);
        int n;
        ctrl(1'b0, 2'h0, s, 2'h3, p);
        clk_n(4);
        wr_rl(r);
        ctrl(1'b0, 2'h0, s, 2'h3, p);
        chk("select", {14'h0, s}, {14'h0, selo});
        clk_n(1);
        ctrl(1'b1, 2'h0, s, 2'h3, p);
        wait_wf(n);
        fclr = 3'h4;
        clk_n(1);
        fclr = 3'h0;
        wait_wf(n);
        chk("wakeup_period", 17'((r + 1) * (16 >> s)), 17'(n));
        clk_n(1);
        chk("wakeup_pad", {16'h0, ~p}, {16'h0, aout});
        chk("wakeup_irq", 17'h1, {16'h0, irq[2]});
    endtask
    task automatic t_alarm(input int a, input logic [3:0] w);
        logic e;
        ctrl(1'b0, 2'h0, 3'h3, 2'(a + 1), 1'b0);
        clk_n(3);
        {av, cw, awr} = {15'h0001, w, 2'(1 << a)};
        clk_n(1);
        awr = 2'h0;
        ctrl(1'b0, 2'(1 << a), 3'h3, 2'(a + 1), 1'b0);
        chk("alarm_write_allowed", 17'h0, {16'h0, awa[a]});
        repeat (10) begin
            fclr = 3'(1 << a);
            clk_n(1);
            {fclr, tick} = 4'h1;
            clk_n(1);
            tick = 1'b0;
            ssm = (ssm == 15'h0) ? 15'h0007 : ssm - 15'h1;
            e = (w == 4'h0) ? (ssm == 15'h0007) : (((ssm ^ 15'h0001) & ((15'h0001 << w) - 15'h0001)) == 15'h0000);
            chk("one_hz", {16'h0, ssm == 15'h0007}, {16'h0, hz});
            clk_n(4);
            chk("subsecond_count", {2'b0, ssm}, {1'b0, ssr});
            chk("alarm_flag", {16'h0, e}, {16'h0, afl[a]});
        end
    endtask

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    initial begin
        {rstn, tick, key_wr, ctrl_wr, reload_wr, wen, pol} = 7'h0;
        {key_data, aen, osel, sel, rl, av, cw, awr, fclr, ssm} = '0;
        {miscompares, cmp_count} = {32'h0, 32'h0};
        clk_n(2);
        rstn = 1'b1;
        t_lock();
        t_wflag();
        for (int s = 0; s < 4; s++) t_period(3'(s), 16'h0002, s[0]);
        t_alarm(0, 4'h0);
        t_alarm(1, 4'h2);
        t_alarm(0, 4'h1);
        key(KEY_RELOCK);
        ctrl(1'b1, 2'h0, 3'h0, 2'h0, 1'b0);
        clk_n(1);
        chk("relock_enable", 17'h0, {16'h0, wte});
        summarize();
    end
endmodule // tb
`default_nettype wire
